/* File: design/ebtu_pkg.sv */
// Constants and types for the emulator break and trace unit
// Notes on behaviour
// R1 - Two break conditions compared continuously, stop emulation
// R2 - Breaking instruction completes; halt at next boundary
// R3 - Match address, opcode, probe or pin, fetched data
// R4 - 22 internal plus 16 probe channels, maskable (opcode fetch flag always compared)
// R5 - Page, paragraph or byte address ranges
// R6 - Four step compares end single stepping
// R7 - Compares offer all relations and variable comparands
// R8 - Trace holds opcode, PC, port 2, probes
// R9 - Trace runs in real-time and step modes
// R10 - One trace qualifier in break condition format
// R11 - Trace modes: always, qualified, pre, post
// R12 - Sampling keeps pace with 0.6 to 3.6 MHz
// R13 - Run continuously or counted steps, optional stops
// R14 - After a break, halt for host interrogation
// R15 - While halted, trace frozen and processor held
package ebtu_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int PROBE_W = 16;
    localparam int CH_W = 38;
    localparam int CH_ADDR_LO = 0;
    localparam int CH_DATA_LO = 12;
    localparam int CH_OPFETCH = 20;
    localparam int CH_START = 21;
    localparam int CH_PROBE_LO = 22;
    localparam logic [CH_W-1:0] CH_ALWAYS_CARE = 38'h00_0010_0000;
    localparam logic [CH_W-1:0] CH_ADDR_MASK = 38'h00_0000_0FFF;
    localparam int SYNC_W = 47;
    localparam int SYNC_PORT2_LO = 38;
    localparam int SYNC_STROBE = 46;
    localparam int TRACE_W = 44;
    localparam int TRACE_AW = 9;
    localparam logic [9:0] TRACE_DEPTH = 10'h01F4;
    localparam logic [8:0] TRACE_LAST = 9'h01F3;
    localparam int STEP_W = 16;
    localparam int N_CMP = 4;
    localparam int REF_CLK_KHZ = 50000;
    localparam int XTAL_MIN_KHZ = 600;
    localparam int XTAL_MAX_KHZ = 3600;
    localparam int XTAL_PER_CYC = 30;
    // Fewest reference clocks between two instruction cycles at top speed
    localparam int CYC_MIN_CLKS =
        (REF_CLK_KHZ * XTAL_PER_CYC + XTAL_MAX_KHZ - 1) / XTAL_MAX_KHZ;
    localparam logic [1:0] RNG_NONE = 2'h0;
    localparam logic [1:0] RNG_PAGE = 2'h1;
    localparam logic [1:0] RNG_PARA = 2'h2;
    localparam logic [1:0] RNG_BYTE = 2'h3;
    localparam logic [2:0] REL_EQ = 3'h0;
    localparam logic [2:0] REL_NE = 3'h1;
    localparam logic [2:0] REL_LT = 3'h2;
    localparam logic [2:0] REL_LE = 3'h3;
    localparam logic [2:0] REL_GT = 3'h4;
    localparam logic [2:0] REL_GE = 3'h5;
    localparam logic [1:0] VAR_ADDR = 2'h0;
    localparam logic [1:0] VAR_DATA = 2'h1;
    localparam logic [1:0] VAR_PORT2 = 2'h2;
    localparam logic [1:0] VAR_PROBE = 2'h3;
    localparam logic [1:0] TMODE_ALWAYS = 2'h0;
    localparam logic [1:0] TMODE_QUAL = 2'h1;
    localparam logic [1:0] TMODE_PRE = 2'h2;
    localparam logic [1:0] TMODE_POST = 2'h3;
    localparam logic [2:0] CAUSE_STEP = 3'h4;
    typedef enum logic [2:0] {
        ST_HALT = 3'h1,
        ST_RUN = 3'h2,
        ST_STEP = 3'h4
    } ebtu_state_t;
endpackage

/* File: design/ebtu_trace_if.sv */
// Port bundle between the control logic and the trace memory
`timescale 1ns/1ps
interface ebtu_trace_if;
    import ebtu_pkg::*;
    logic wr_en;
    logic [TRACE_AW-1:0] wr_addr;
    logic [TRACE_W-1:0] wr_data;
    logic [TRACE_AW-1:0] rd_addr;
    logic [TRACE_W-1:0] rd_data;
    modport ctrl (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
    modport mem (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface

/* File: design/ebtu_trace_mem.sv */
// Trace record memory with registered read data
`timescale 1ns/1ps
module ebtu_trace_mem
    import ebtu_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    ebtu_trace_if.mem port
);
    logic [TRACE_W-1:0] store [0:(1 << TRACE_AW)-1];

    always_ff @(posedge clk) begin
        if (port.wr_en) begin
            store[port.wr_addr] <= port.wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            port.rd_data <= '0;
        end else begin
            port.rd_data <= store[port.rd_addr];
        end
    end
endmodule

/* File: design/ebtu_unit.sv */
// Break, step compare and trace capture logic of the emulator
`timescale 1ns/1ps
module ebtu_unit
    import ebtu_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic SRST,
    input wire logic CYC_STROBE,
    input wire logic [ADDR_W-1:0] CPU_ADDR,
    input wire logic [DATA_W-1:0] CPU_DATA,
    input wire logic CPU_OPFETCH,
    input wire logic CPU_INSTR_START,
    input wire logic [DATA_W-1:0] CPU_PORT2,
    input wire logic [PROBE_W-1:0] PROBE,
    input wire logic GO_REQ,
    input wire logic STEP_REQ,
    input wire logic [STEP_W-1:0] STEP_COUNT,
    input wire logic [1:0] BRK_ENABLE,
    input wire logic [CH_W-1:0] BRK_A_VALUE,
    input wire logic [CH_W-1:0] BRK_A_CARE,
    input wire logic [1:0] BRK_A_RANGE,
    input wire logic [3:0] BRK_A_LO,
    input wire logic [3:0] BRK_A_HI,
    input wire logic [CH_W-1:0] BRK_B_VALUE,
    input wire logic [CH_W-1:0] BRK_B_CARE,
    input wire logic [1:0] BRK_B_RANGE,
    input wire logic [3:0] BRK_B_LO,
    input wire logic [3:0] BRK_B_HI,
    input wire logic [N_CMP-1:0] CMP_ENABLE,
    input wire logic [2*N_CMP-1:0] CMP_VAR_SEL,
    input wire logic [3*N_CMP-1:0] CMP_REL,
    input wire logic [N_CMP-1:0] CMP_USE_VAR,
    input wire logic [2*N_CMP-1:0] CMP_REF_SEL,
    input wire logic [16*N_CMP-1:0] CMP_CONST,
    input wire logic [CH_W-1:0] QUAL_VALUE,
    input wire logic [CH_W-1:0] QUAL_CARE,
    input wire logic [1:0] QUAL_RANGE,
    input wire logic [3:0] QUAL_LO,
    input wire logic [3:0] QUAL_HI,
    input wire logic [1:0] TRACE_MODE,
    input wire logic TRACE_ARM,
    input wire logic [TRACE_AW-1:0] TRACE_RD_ADDR,
    output logic EMU_RUN,
    output logic HALTED,
    output logic [2:0] HALT_CAUSE,
    output logic [9:0] TRACE_COUNT,
    output logic [TRACE_W-1:0] TRACE_RD_DATA
);
    // Address range digits plus masked channel compare
    function automatic logic cond_hit(
        input logic [CH_W-1:0] val,
        input logic [CH_W-1:0] care,
        input logic [CH_W-1:0] ch,
        input logic [1:0] kind,
        input logic [3:0] lo,
        input logic [3:0] hi
    );
        logic [CH_W-1:0] m;
        logic rng;
        m = care | CH_ALWAYS_CARE; // R4
        rng = 1'b1;
        if (kind != RNG_NONE) begin
            m = m & ~CH_ADDR_MASK;
        end
        case (kind) // R5
            RNG_PAGE: rng = ch[11:8] >= lo && ch[11:8] <= hi;
            RNG_PARA: rng = ch[11:8] == val[11:8] &&
                            ch[7:4] >= lo && ch[7:4] <= hi;
            RNG_BYTE: rng = ch[11:4] == val[11:4] &&
                            ch[3:0] >= lo && ch[3:0] <= hi;
            default: rng = 1'b1;
        endcase
        return rng && (((ch ^ val) & m) == '0);
    endfunction

    function automatic logic [15:0] var_val(
        input logic [1:0] sel,
        input logic [CH_W-1:0] ch,
        input logic [DATA_W-1:0] p2
    );
        logic [15:0] v;
        case (sel)
            VAR_ADDR: v = {4'h0, ch[CH_ADDR_LO +: ADDR_W]};
            VAR_DATA: v = {8'h00, ch[CH_DATA_LO +: DATA_W]};
            VAR_PORT2: v = {8'h00, p2};
            default: v = ch[CH_PROBE_LO +: PROBE_W];
        endcase
        return v;
    endfunction

    function automatic logic rel_ok(
        input logic [15:0] a,
        input logic [15:0] b,
        input logic [2:0] rel
    );
        logic r;
        case (rel) // R7
            REL_EQ: r = a == b;
            REL_NE: r = a != b;
            REL_LT: r = a < b;
            REL_LE: r = a <= b;
            REL_GT: r = a > b;
            REL_GE: r = a >= b;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    ebtu_trace_if tr_if ();

    ebtu_trace_mem u_mem (
        .clk(REF_CLK),
        .srst(SRST),
        .port(tr_if.mem)
    );

    // Processor pins cross in through two flops
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic strobe_prev;

    always_ff @(posedge REF_CLK) begin // R12
        if (SRST) begin
            sync1 <= '0;
            sync2 <= '0;
            strobe_prev <= 1'b0;
        end else begin
            sync1 <= {CYC_STROBE, CPU_PORT2, PROBE, CPU_INSTR_START,
                      CPU_OPFETCH, CPU_DATA, CPU_ADDR};
            sync2 <= sync1;
            strobe_prev <= sync2[SYNC_STROBE];
        end
    end

    logic [CH_W-1:0] chan;
    logic [DATA_W-1:0] port2;
    logic cyc_ev;
    logic boundary;
    logic hit_a;
    logic hit_b;
    logic qual_hit;
    logic [N_CMP-1:0] cmp_hit;

    assign chan = sync2[CH_W-1:0]; // R3
    assign port2 = sync2[SYNC_PORT2_LO +: DATA_W];
    assign cyc_ev = sync2[SYNC_STROBE] & ~strobe_prev;
    assign boundary = chan[CH_START];
    assign hit_a = BRK_ENABLE[0] & cond_hit(BRK_A_VALUE, BRK_A_CARE, chan,
        BRK_A_RANGE, BRK_A_LO, BRK_A_HI); // R1
    assign hit_b = BRK_ENABLE[1] & cond_hit(BRK_B_VALUE, BRK_B_CARE, chan,
        BRK_B_RANGE, BRK_B_LO, BRK_B_HI); // R1
    assign qual_hit = cond_hit(QUAL_VALUE, QUAL_CARE, chan,
        QUAL_RANGE, QUAL_LO, QUAL_HI); // R10

    for (genvar i = 0; i < N_CMP; i++) begin : g_cmp
        logic [15:0] lhs;
        logic [15:0] rhs;
        assign lhs = var_val(CMP_VAR_SEL[2*i +: 2], chan, port2);
        assign rhs = CMP_USE_VAR[i] ? var_val(CMP_REF_SEL[2*i +: 2], chan,
            port2) : CMP_CONST[16*i +: 16]; // R7
        assign cmp_hit[i] = CMP_ENABLE[i] & rel_ok(lhs, rhs,
            CMP_REL[3*i +: 3]); // R6
    end

    // Emulation control
    ebtu_state_t state;
    ebtu_state_t next_state;
    logic [STEP_W-1:0] step_left;
    logic [STEP_W-1:0] next_step_left;
    logic [2:0] pend;
    logic [2:0] next_pend;
    logic stepped;
    logic next_stepped;
    logic [2:0] cause;
    logic [2:0] next_cause;
    logic done_instr;
    logic last_step;

    assign done_instr = cyc_ev & boundary & stepped;
    assign last_step = state == ST_STEP && step_left == 16'h0001;

    always_comb begin
        next_state = state;
        next_step_left = step_left;
        next_pend = pend;
        next_stepped = stepped;
        next_cause = cause;
        case (state)
            ST_HALT: begin
                if (GO_REQ) begin // R13
                    next_state = ST_RUN;
                    next_pend = '0;
                    next_stepped = 1'b0;
                    next_cause = '0;
                end else if (STEP_REQ && STEP_COUNT != '0) begin // R13
                    next_state = ST_STEP;
                    next_step_left = STEP_COUNT;
                    next_pend = '0;
                    next_stepped = 1'b0;
                    next_cause = '0;
                end
            end
            ST_RUN, ST_STEP: begin
                if (cyc_ev) begin
                    // Hits are held until the instruction ends
                    next_pend = (done_instr ? 3'h0 : pend) |
                        {(state == ST_STEP) & (|cmp_hit), hit_b, hit_a};
                    next_stepped = stepped | boundary;
                end
                if (done_instr) begin // R2
                    if (pend != '0 || last_step) begin // R6
                        next_state = ST_HALT; // R14
                        next_cause = pend | (last_step ? CAUSE_STEP : 3'h0);
                    end else if (state == ST_STEP) begin
                        next_step_left = step_left - 16'h0001;
                    end
                end
            end
            default: next_state = ST_HALT;
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            state <= ST_HALT;
            step_left <= '0;
            pend <= '0;
            stepped <= 1'b0;
            cause <= '0;
        end else begin
            state <= next_state;
            step_left <= next_step_left;
            pend <= next_pend;
            stepped <= next_stepped;
            cause <= next_cause;
        end
    end

    assign EMU_RUN = state != ST_HALT; // R15
    assign HALTED = state == ST_HALT; // R14
    assign HALT_CAUSE = cause;

    // Trace capture
    logic [TRACE_AW-1:0] wptr;
    logic [TRACE_AW-1:0] next_wptr;
    logic [9:0] count;
    logic [9:0] next_count;
    logic trig;
    logic next_trig;
    logic [TRACE_AW-1:0] post_left;
    logic [TRACE_AW-1:0] next_post_left;
    logic wr;
    logic trace_live;
    logic [9:0] rd_sum;

    assign trace_live = cyc_ev && state != ST_HALT; // R9

    always_comb begin
        next_wptr = wptr;
        next_count = count;
        next_trig = trig;
        next_post_left = post_left;
        wr = 1'b0;
        if (state == ST_HALT && TRACE_ARM) begin
            next_wptr = '0;
            next_count = '0;
            next_trig = 1'b0;
            next_post_left = '0;
        end else if (trace_live) begin
            case (TRACE_MODE) // R11
                TMODE_ALWAYS: wr = 1'b1;
                TMODE_QUAL: wr = qual_hit;
                TMODE_PRE: begin
                    if (!trig && qual_hit) begin
                        next_trig = 1'b1;
                    end else if (!trig) begin
                        wr = 1'b1;
                    end
                end
                default: begin
                    if (!trig && qual_hit) begin
                        next_trig = 1'b1;
                        next_post_left = TRACE_LAST;
                        wr = 1'b1;
                    end else if (trig && post_left != '0) begin
                        next_post_left = post_left - 9'h001;
                        wr = 1'b1;
                    end
                end
            endcase
        end
        if (wr) begin // R8
            next_wptr = (wptr == TRACE_LAST) ? 9'h000 : wptr + 9'h001;
            next_count = (count == TRACE_DEPTH) ? count : count + 10'h001;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            wptr <= '0;
            count <= '0;
            trig <= 1'b0;
            post_left <= '0;
        end else begin
            wptr <= next_wptr;
            count <= next_count;
            trig <= next_trig;
            post_left <= next_post_left;
        end
    end

    // Read index 0 is the oldest record held
    assign rd_sum = ((count == TRACE_DEPTH) ? {1'b0, wptr} : 10'h000) +
        {1'b0, TRACE_RD_ADDR};
    assign tr_if.rd_addr = (rd_sum >= TRACE_DEPTH) ?
        TRACE_AW'(rd_sum - TRACE_DEPTH) : rd_sum[TRACE_AW-1:0];
    assign tr_if.wr_en = wr;
    assign tr_if.wr_addr = wptr;
    assign tr_if.wr_data = {chan[CH_PROBE_LO +: PROBE_W], port2,
        chan[CH_ADDR_LO +: ADDR_W], chan[CH_DATA_LO +: DATA_W]}; // R8
    assign TRACE_COUNT = count;
    assign TRACE_RD_DATA = tr_if.rd_data;

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SRST);

    a_brk_halt: // R1
    assert property (state == ST_RUN && done_instr && pend[1:0] != '0
        |=> state == ST_HALT && cause[1:0] != '0)
        else $error("break did not halt at boundary");
    a_brk_midinstr: // R2
    assert property (state == ST_RUN && cyc_ev && !boundary && !GO_REQ
        |=> state == ST_RUN)
        else $error("halt inside an instruction");
    a_step_compare: // R6
    assert property (state == ST_STEP && done_instr && pend[2]
        |=> state == ST_HALT ##1 state == ST_HALT)
        else $error("step compare did not stop stepping");
    a_step_count: // R13
    assert property (state == ST_STEP && done_instr && step_left == 16'h0001
        |=> HALTED && HALT_CAUSE[2])
        else $error("step count did not end stepping");
    a_go_start: // R13
    assert property (HALTED && GO_REQ |=> EMU_RUN && HALT_CAUSE == 3'h0)
        else $error("run request not taken");
    a_halt_hold: // R15
    assert property (HALTED |-> !tr_if.wr_en)
        else $error("trace written while halted");
    a_qual_only: // R11
    assert property (TRACE_MODE == TMODE_QUAL && tr_if.wr_en |-> qual_hit)
        else $error("qualified trace wrote without a match");
    a_pre_stop: // R11
    assert property (TRACE_MODE == TMODE_PRE && trig |-> !tr_if.wr_en)
        else $error("pre-trigger trace kept writing");
    a_post_end: // R11
    assert property (TRACE_MODE == TMODE_POST && trig && post_left == '0
        |-> !tr_if.wr_en)
        else $error("post-trigger trace overran");
    a_ptr_wrap: // R8
    assert property (tr_if.wr_en && wptr == TRACE_LAST
        |=> wptr == 9'h000 && count == TRACE_DEPTH)
        else $error("trace pointer wrap wrong");

    c_break_halt: cover property (state == ST_RUN ##1 HALTED && cause[0]);
    c_post_full: cover property (trig && post_left == 9'h001 && tr_if.wr_en);
    c_step_cmp: cover property (state == ST_STEP ##1 HALTED && cause[2]);
endmodule

/* File: verif/ebtu_cpu_model.sv */
// Emulated processor pins, driven one instruction cycle at a time
`timescale 1ns/1ps
module ebtu_cpu_model
    import ebtu_pkg::*;
(
    input wire logic clk,
    output logic strobe,
    output logic [ADDR_W-1:0] addr,
    output logic [DATA_W-1:0] data,
    output logic opfetch,
    output logic start,
    output logic [DATA_W-1:0] port2,
    output logic [PROBE_W-1:0] probe
);
    int ev_count = 0;

    initial begin
        strobe = 1'b0;
        {addr, data, opfetch, start, port2, probe} = '0;
    end

    // One cycle is 421 clocks, just longer than the 417 clocks of the fastest cycle rate
    task automatic cycle(logic [11:0] a, logic [7:0] d, logic f, logic s,
                         logic [7:0] p, logic [15:0] pr);
        @(posedge clk);
        {addr, data, opfetch, start, port2, probe} <= {a, d, f, s, p, pr};
        repeat (200) @(posedge clk);
        strobe <= 1'b1;
        ev_count++;
        repeat (210) @(posedge clk);
        strobe <= 1'b0;
        repeat (10) @(posedge clk);
        // Hold time over: the lines no longer carry the cycle's values
        {addr, data, opfetch, start, port2, probe} <=
            ~{addr, data, opfetch, start, port2, probe};
    endtask
endmodule

/* File: verif/emulator_break_trace_unit_test.sv */
// Self-checking bench for the break, compare and trace unit
`timescale 1ns/1ps
module emulator_break_trace_unit_test;
    import ebtu_pkg::*;
    typedef struct {logic [2:0] cause; int evs;} ebtu_note_t;
    logic ref_clk = 0, srst = 1, go_req = 0, step_req = 0, trace_arm = 0;
    logic cyc_strobe, cpu_opfetch, cpu_instr_start, emu_run, halted;
    logic [ADDR_W-1:0] cpu_addr;
    logic [DATA_W-1:0] cpu_data, cpu_port2;
    logic [PROBE_W-1:0] probe;
    logic [STEP_W-1:0] step_count = '0;
    logic [1:0] brk_enable = '0, brk_a_range = '0, brk_b_range = '0;
    logic [1:0] qual_range = '0, trace_mode = '0;
    logic [3:0] brk_a_lo = '0, brk_a_hi = '0, brk_b_lo = '0, brk_b_hi = '0;
    logic [3:0] qual_lo = '0, qual_hi = '0, cmp_enable = '0, cmp_use_var = '0;
    logic [CH_W-1:0] brk_a_value = '0, brk_a_care = '0, brk_b_value = '0;
    logic [CH_W-1:0] brk_b_care = '0, qual_value = '0, qual_care = '0;
    logic [7:0] cmp_var_sel = '0, cmp_ref_sel = '0;
    logic [11:0] cmp_rel = '0;
    logic [63:0] cmp_const = '0;
    logic [TRACE_AW-1:0] trace_rd_addr = '0;
    logic [2:0] halt_cause;
    logic [9:0] trace_count;
    logic [TRACE_W-1:0] trace_rd_data;
    logic halted_q = 1'b1;
    int mismatches = 0, checks = 0, cycles = 0, seed = 32'hb3bf_b439;
    ebtu_note_t notes[$];

    always #10 ref_clk = ~ref_clk;

    ebtu_cpu_model cpu (.clk(ref_clk), .strobe(cyc_strobe), .addr(cpu_addr),
        .data(cpu_data), .opfetch(cpu_opfetch), .start(cpu_instr_start),
        .port2(cpu_port2), .probe(probe));

    ebtu_unit DUT (.REF_CLK(ref_clk), .SRST(srst), .CYC_STROBE(cyc_strobe),
        .CPU_ADDR(cpu_addr), .CPU_DATA(cpu_data), .CPU_OPFETCH(cpu_opfetch),
        .CPU_INSTR_START(cpu_instr_start), .CPU_PORT2(cpu_port2),
        .PROBE(probe), .GO_REQ(go_req), .STEP_REQ(step_req),
        .STEP_COUNT(step_count), .BRK_ENABLE(brk_enable),
        .BRK_A_VALUE(brk_a_value), .BRK_A_CARE(brk_a_care),
        .BRK_A_RANGE(brk_a_range), .BRK_A_LO(brk_a_lo), .BRK_A_HI(brk_a_hi),
        .BRK_B_VALUE(brk_b_value), .BRK_B_CARE(brk_b_care),
        .BRK_B_RANGE(brk_b_range), .BRK_B_LO(brk_b_lo), .BRK_B_HI(brk_b_hi),
        .CMP_ENABLE(cmp_enable), .CMP_VAR_SEL(cmp_var_sel),
        .CMP_REL(cmp_rel), .CMP_USE_VAR(cmp_use_var),
        .CMP_REF_SEL(cmp_ref_sel), .CMP_CONST(cmp_const),
        .QUAL_VALUE(qual_value), .QUAL_CARE(qual_care),
        .QUAL_RANGE(qual_range), .QUAL_LO(qual_lo), .QUAL_HI(qual_hi),
        .TRACE_MODE(trace_mode), .TRACE_ARM(trace_arm),
        .TRACE_RD_ADDR(trace_rd_addr), .EMU_RUN(emu_run), .HALTED(halted),
        .HALT_CAUSE(halt_cause), .TRACE_COUNT(trace_count),
        .TRACE_RD_DATA(trace_rd_data));

    task automatic check(string what, logic [47:0] seen, logic [47:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("Checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Each halt takes the oldest note: cause and cycle it stopped after
    always @(posedge ref_clk) begin
        halted_q <= halted;
        if (!srst && halted === 1'b1 && halted_q === 1'b0) begin
            if (notes.size() == 0) begin
                check("unexpected halt", 1, 0);
            end else begin
                check("halt cause", halt_cause, notes[0].cause);
                check("halt cycle", cpu.ev_count, notes[0].evs);
                void'(notes.pop_front());
            end
        end
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 60000) begin
            mismatches++;
            end_of_test();
        end
    end

    task automatic ins(logic [11:0] a);
        cpu.cycle(a, 8'($random(seed)), 1'b1, 1'b1, 8'($random(seed)),
                  16'($random(seed)));
    endtask

    task automatic start(logic step, logic [2:0] cause, int evs);
        notes.push_back('{cause, evs});
        cpu.ev_count = 0;
        @(posedge ref_clk);
        go_req <= !step;
        step_req <= step;
        @(posedge ref_clk);
        go_req <= 1'b0;
        step_req <= 1'b0;
        @(posedge ref_clk);
        #1 check("run", {emu_run, halted, halt_cause}, 5'h10);
    endtask

    task automatic wait_halt();
        for (int i = 0; i < 20 && halted !== 1'b1; i++) @(posedge ref_clk);
        repeat (2) @(posedge ref_clk);
        #1 check("stopped", {emu_run, halted}, 2'b01);
    endtask

    task automatic brk_a(logic [1:0] rng, logic [11:0] a, logic [3:0] lo,
                         logic [3:0] hi);
        brk_enable <= 2'b01;
        brk_a_range <= rng;
        brk_a_value <= CH_ALWAYS_CARE | CH_W'(a);
        brk_a_care <= CH_ALWAYS_CARE | CH_ADDR_MASK;
        brk_a_lo <= lo;
        brk_a_hi <= hi;
    endtask

    task automatic read_rec(logic [8:0] k, logic [43:0] exp);
        @(posedge ref_clk);
        trace_rd_addr <= k;
        repeat (2) @(posedge ref_clk);
        #1 check("trace record", trace_rd_data, exp);
    endtask

    initial begin
        static logic [1:0] rk [3] = '{RNG_PAGE, RNG_PARA, RNG_BYTE};
        static logic [11:0] rmiss [3] = '{12'h600, 12'h250, 12'h34a};
        static logic [11:0] rhit [3] = '{12'h500, 12'h240, 12'h347};
        static logic [11:0] rval [3] = '{12'h000, 12'h200, 12'h340};
        static logic [3:0] rlo [3] = '{4'h3, 4'h2, 4'h7};
        static logic [3:0] rhi [3] = '{4'h5, 4'h4, 4'h9};
        static logic [11:0] ca [4] = '{12'h0f0, 12'h100, 12'h110, 12'h120};
        static int idx [6] = '{1, 0, 0, 0, 2, 1};
        static int n [4] = '{6, 2, 2, 4};
        logic [43:0] rec [6];
        logic [15:0] pr;
        logic [9:0] saved;
        repeat (16) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        #1 check("reset", {emu_run, halted, halt_cause, trace_count},
                 15'h2000);
        for (int k = 0; k < 3; k++) begin
            brk_a(rk[k], rval[k], rlo[k], rhi[k]);
            start(1'b0, 3'h1, 3);
            ins(rmiss[k]);
            ins(rhit[k]);
            ins(12'h0c0);
            wait_halt();
        end
        brk_enable <= 2'b10;
        brk_b_value <= CH_ALWAYS_CARE | 38'h0a_5000;
        brk_b_care <= CH_ALWAYS_CARE | 38'h0f_f000;
        start(1'b0, 3'h2, 5);
        cpu.cycle(12'h020, 8'h11, 1'b1, 1'b1, 8'h00, 16'h0000);
        cpu.cycle(12'h021, 8'ha5, 1'b0, 1'b0, 8'h00, 16'h0000);
        cpu.cycle(12'h022, 8'ha5, 1'b1, 1'b1, 8'h00, 16'h0000);
        cpu.cycle(12'h023, 8'h00, 1'b0, 1'b0, 8'h00, 16'h0000);
        ins(12'h024);
        wait_halt();
        // Probe value break: only the probe channels and the always-compared opcode fetch flag are compared
        brk_b_value <= CH_ALWAYS_CARE | {16'h8001, 22'h0};
        brk_b_care <= CH_ALWAYS_CARE | {16'hffff, 22'h0};
        start(1'b0, 3'h2, 3);
        cpu.cycle(12'h060, 8'h00, 1'b1, 1'b1, 8'h00, 16'h8000);
        cpu.cycle(12'h061, 8'h00, 1'b1, 1'b1, 8'h00, 16'h8001);
        ins(12'h062);
        wait_halt();
        brk_enable <= 2'b00;
        step_count <= 16'h0003;
        start(1'b1, CAUSE_STEP, 4);
        for (int i = 0; i < 4; i++) ins(12'h050);
        wait_halt();
        step_count <= 16'h0064;
        for (int r = 0; r < 6; r++) begin
            cmp_enable <= 4'b0001 << (r % 4);
            cmp_rel <= 12'(r) << (3 * (r % 4));
            cmp_const <= 64'h0100 << (16 * (r % 4));
            start(1'b1, CAUSE_STEP, idx[r] + 2);
            for (int j = 0; j < idx[r] + 2; j++) ins(ca[j]);
            wait_halt();
        end
        cmp_enable <= 4'b0001;
        cmp_rel <= '0;
        cmp_var_sel <= {6'h00, VAR_PORT2};
        cmp_ref_sel <= {6'h00, VAR_DATA};
        cmp_use_var <= 4'b0001;
        start(1'b1, CAUSE_STEP, 3);
        cpu.cycle(12'h030, 8'h12, 1'b1, 1'b1, 8'h34, 16'h0000);
        cpu.cycle(12'h031, 8'h56, 1'b1, 1'b1, 8'h56, 16'h0000);
        ins(12'h032);
        wait_halt();
        // Probe variable in the last slot, greater-than at its edge
        cmp_enable <= 4'b1000;
        cmp_var_sel <= {VAR_PROBE, 6'h00};
        cmp_rel <= {REL_GT, 9'h000};
        cmp_use_var <= 4'b0000;
        cmp_const <= {16'h7fff, 48'h0};
        start(1'b1, CAUSE_STEP, 3);
        cpu.cycle(12'h038, 8'h00, 1'b1, 1'b1, 8'h00, 16'h7fff);
        cpu.cycle(12'h039, 8'h00, 1'b1, 1'b1, 8'h00, 16'h8000);
        ins(12'h03a);
        wait_halt();
        cmp_enable <= '0;
        qual_value <= CH_ALWAYS_CARE | 38'h00_0040_0000;
        qual_care <= CH_ALWAYS_CARE | 38'h00_0040_0000;
        brk_a(RNG_NONE, 12'hf00, 4'h0, 4'h0);
        for (int m = 0; m < 4; m++) begin
            @(posedge ref_clk);
            trace_mode <= 2'(m);
            trace_arm <= 1'b1;
            @(posedge ref_clk);
            trace_arm <= 1'b0;
            @(posedge ref_clk);
            #1 check("armed count", trace_count, 0);
            start(1'b0, 3'h1, 8);
            for (int i = 0; i < 6; i++) begin
                pr = {15'($random(seed)), i == 2 || i == 4};
                rec[i] = {pr, 8'($random(seed)), 12'h010 + 12'(i),
                          8'($random(seed))};
                cpu.cycle(rec[i][19:8], rec[i][7:0], 1'b1, 1'b1,
                          rec[i][27:20], pr);
            end
            check("trace count", trace_count, n[m]);
            ins(12'hf00);
            ins(12'hf01);
            wait_halt();
            saved = trace_count;
            ins(12'h040);
            check("frozen count", trace_count, saved);
            if (m == 0) begin
                read_rec(9'h000, rec[0]);
                read_rec(9'h005, rec[5]);
            end
        end
        check("pending halts", notes.size(), 0);
        end_of_test();
    end
endmodule
